// ### core/resizer_b_output_address_regs.sv
`timescale 1ns/1ps
module resizer_b_output_address_regs
  import rsz_out_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              pixelValid,
  input  wire logic [23:0]       pixelRgb,
  output logic      [31:0]       pixelOut,
  input  wire logic              lineStart,
  input  wire logic [LINE_W-1:0] lineIndex,
  output logic      [31:0]       lineAddr,
  output logic      [31:0]       baseAddr,
  output logic      [31:0]       startAddr,
  output logic                   rgbWidthSelect,
  output logic                   horizontalReversal,
  output logic                   alignError
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMetaQ;
  logic rstSyncQ;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMetaQ <= 1'b0;
      rstSyncQ <= 1'b0;
    end else begin
      rstMetaQ <= 1'b1;
      rstSyncQ <= rstMetaQ;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic access;
  logic wrEn;
  logic hit;

  assign access  = psel && penable;
  assign wrEn    = access && pwrite && clkEn;
  assign pready  = 1'b1;
  assign hit     = paddr inside {OFF_ALPHA, OFF_BASE_HIGH, OFF_BASE_LOW, OFF_START_HIGH,
                                 OFF_START_LOW, OFF_CONTROL, OFF_PITCH, OFF_STATUS,
                                 OFF_LINE_ADDR};
  assign pslverr = access && !hit;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [ALPHA_MSB:0] alphaQ;
  logic [2:0]         ctlQ;
  logic [15:0]        pitchQ;
  logic [15:0]        baseHighQ;
  logic [15:0]        baseLowQ;
  logic [15:0]        startHighQ;
  logic [15:0]        startLowQ;
  logic               basePendQ;
  logic               startPendQ;

  always_ff @(posedge core_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      alphaQ <= ALPHA_RESET;
    end else if (wrEn && paddr == OFF_ALPHA) begin
      alphaQ <= pwdata[ALPHA_MSB:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      ctlQ <= CTL_RESET;
    end else if (wrEn && paddr == OFF_CONTROL) begin
      ctlQ <= pwdata[2:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      pitchQ <= PITCH_RESET;
    end else if (wrEn && paddr == OFF_PITCH) begin
      pitchQ <= pwdata[15:0];
    end
  end

  addr_pair baseRegs (
    .clk      (core_clk),
    .rstN     (rstSyncQ),
    .clkEn    (clkEn),
    .wrHigh   (wrEn && paddr == OFF_BASE_HIGH),
    .wrLow    (wrEn && paddr == OFF_BASE_LOW),
    .wdata    (pwdata[HALF_MSB:0]),
    .highQ    (baseHighQ),
    .lowQ     (baseLowQ),
    .activeQ  (baseAddr),
    .pendingQ (basePendQ)
  );

  addr_pair startRegs (
    .clk      (core_clk),
    .rstN     (rstSyncQ),
    .clkEn    (clkEn),
    .wrHigh   (wrEn && paddr == OFF_START_HIGH),
    .wrLow    (wrEn && paddr == OFF_START_LOW),
    .wdata    (pwdata[HALF_MSB:0]),
    .highQ    (startHighQ),
    .lowQ     (startLowQ),
    .activeQ  (startAddr),
    .pendingQ (startPendQ)
  );

  assign rgbWidthSelect     = ctlQ[CTL_WIDTH_SEL_BIT];
  assign horizontalReversal = ctlQ[CTL_HREV_BIT];

  // Software alignment duty is only flagged, never enforced: the resizer
  // must still write where it was told.
  logic [2:0] needLow;
  logic [2:0] maskLow;
  always_comb begin
    if (ctlQ[CTL_RGB_EN_BIT] && !rgbWidthSelect) begin
      maskLow = 3'h7;
      needLow = 3'h0;
    end else begin
      maskLow = 3'h3;
      needLow = horizontalReversal ? 3'h3 : 3'h0;
    end
  end
  assign alignError = ((baseAddr[2:0] & maskLow) != needLow) ||
                      ((startAddr[2:0] & maskLow) != needLow);

  // ----------------------------------------------------------------
  // Pixel packing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      pixelOut <= 32'h0000_0000;
    end else if (clkEn && pixelValid) begin
      if (!rgbWidthSelect) begin
        pixelOut <= {alphaQ, pixelRgb};
      end else begin
        pixelOut <= {16'h0000, pixelRgb[23:19], pixelRgb[15:10], pixelRgb[7:3]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Line address
  // ----------------------------------------------------------------
  logic [31:0] lineOffset;
  assign lineOffset = 32'(lineIndex) * 32'(pitchQ);

  always_ff @(posedge core_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      lineAddr <= 32'h0000_0000;
    end else if (clkEn && lineStart) begin
      lineAddr <= startAddr + lineOffset;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      OFF_ALPHA:      prdata = {24'h000000, alphaQ};
      OFF_BASE_HIGH:  prdata = {16'h0000, baseHighQ};
      OFF_BASE_LOW:   prdata = {16'h0000, baseLowQ};
      OFF_START_HIGH: prdata = {16'h0000, startHighQ};
      OFF_START_LOW:  prdata = {16'h0000, startLowQ};
      OFF_CONTROL:    prdata = {29'h0, ctlQ};
      OFF_PITCH:      prdata = {16'h0000, pitchQ};
      OFF_STATUS:     prdata = {29'h0, alignError, startPendQ, basePendQ};
      OFF_LINE_ADDR:  prdata = lineAddr;
      default:        prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_startLowAlone;
    clkEn && !startPendQ && wrEn && paddr == OFF_START_LOW;
  endsequence

  sequence s_startHeld;
    $stable(startAddr) ##1 $stable(startAddr);
  endsequence

  property p_alphaInsert;
    @(posedge core_clk) disable iff (!rstSyncQ)
      clkEn && pixelValid && !rgbWidthSelect |=> pixelOut[31:24] == $past(alphaQ);
  endproperty
  a_alphaInsert: assert property (p_alphaInsert) else $error("alpha not inserted");

  property p_rgb565;
    @(posedge core_clk) disable iff (!rstSyncQ)
      clkEn && pixelValid && rgbWidthSelect |=> pixelOut[31:16] == 16'h0000;
  endproperty
  a_rgb565: assert property (p_rgb565) else $error("upper half not zero in 16-bit");

  property p_baseHighWrite;
    @(posedge core_clk) disable iff (!rstSyncQ)
      wrEn && paddr == OFF_BASE_HIGH |=> baseHighQ == $past(pwdata[15:0]);
  endproperty
  a_baseHighWrite: assert property (p_baseHighWrite) else $error("base high lost");

  property p_baseLowWrite;
    @(posedge core_clk) disable iff (!rstSyncQ)
      wrEn && paddr == OFF_BASE_LOW |=> baseLowQ == $past(pwdata[15:0]);
  endproperty
  a_baseLowWrite: assert property (p_baseLowWrite) else $error("base low lost");

  property p_startHighWrite;
    @(posedge core_clk) disable iff (!rstSyncQ)
      wrEn && paddr == OFF_START_HIGH |=> startHighQ == $past(pwdata[15:0]);
  endproperty
  a_startHighWrite: assert property (p_startHighWrite) else $error("start high lost");

  property p_startLowWrite;
    @(posedge core_clk) disable iff (!rstSyncQ)
      wrEn && paddr == OFF_START_LOW |=> startLowQ == $past(pwdata[15:0]);
  endproperty
  a_startLowWrite: assert property (p_startLowWrite) else $error("start low lost");

  property p_lineAddr;
    @(posedge core_clk) disable iff (!rstSyncQ)
      clkEn && lineStart |=> lineAddr == $past(startAddr) + $past(lineOffset);
  endproperty
  a_lineAddr: assert property (p_lineAddr) else $error("line address wrong");

  property p_pairJoin;
    @(posedge core_clk) disable iff (!rstSyncQ)
      s_startLowAlone |=> s_startHeld;
  endproperty
  a_pairJoin: assert property (p_pairJoin) else $error("half write took effect");

endmodule

// ### core/rsz_out_pkg.sv
package rsz_out_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ALPHA      = 8'h00;
  localparam logic [7:0] OFF_BASE_HIGH  = 8'h04;
  localparam logic [7:0] OFF_BASE_LOW   = 8'h08;
  localparam logic [7:0] OFF_START_HIGH = 8'h0c;
  localparam logic [7:0] OFF_START_LOW  = 8'h10;
  localparam logic [7:0] OFF_CONTROL    = 8'h14;
  localparam logic [7:0] OFF_PITCH      = 8'h18;
  localparam logic [7:0] OFF_STATUS     = 8'h1c;
  localparam logic [7:0] OFF_LINE_ADDR  = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          ALPHA_MSB         = 7;
  localparam int          HALF_MSB          = 15;
  localparam int          CTL_WIDTH_SEL_BIT = 0;
  localparam int          CTL_HREV_BIT      = 1;
  localparam int          CTL_RGB_EN_BIT    = 2;
  localparam logic [15:0] HALF_RESET        = 16'h0000;
  localparam logic [7:0]  ALPHA_RESET       = 8'h00;
  localparam logic [2:0]  CTL_RESET         = 3'h0;
  localparam logic [15:0] PITCH_RESET       = 16'h0000;
  localparam int          ADDR_W            = 8;
  localparam int          LINE_W            = 13;

  // Address half tracking for the pairing of high and low writes
  typedef enum logic [1:0] {
    PAIR_EMPTY  = 2'b00,
    PAIR_HIGH   = 2'b01,
    PAIR_BOTH   = 2'b11,
    PAIR_LOW    = 2'b10
  } pair_e;

endpackage

// ### core/addr_pair.sv
`timescale 1ns/1ps
// Holds one 32-bit address as two 16-bit halves; publishes the joined
// value only once both halves have been written since the last publish.
module addr_pair
  import rsz_out_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstN,
  input  wire logic        clkEn,
  input  wire logic        wrHigh,
  input  wire logic        wrLow,
  input  wire logic [15:0] wdata,
  output logic      [15:0] highQ,
  output logic      [15:0] lowQ,
  output logic      [31:0] activeQ,
  output logic             pendingQ
);

  pair_e pairQ;
  pair_e pairD;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      highQ <= HALF_RESET;
    end else if (clkEn && wrHigh) begin
      highQ <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lowQ <= HALF_RESET;
    end else if (clkEn && wrLow) begin
      lowQ <= wdata;
    end
  end

  always_comb begin
    case (pairQ)
      PAIR_EMPTY: pairD = wrHigh ? PAIR_HIGH : (wrLow ? PAIR_LOW : PAIR_EMPTY);
      PAIR_HIGH:  pairD = wrLow ? PAIR_BOTH : PAIR_HIGH;
      PAIR_LOW:   pairD = wrHigh ? PAIR_BOTH : PAIR_LOW;
      // A half written while publishing opens the next pair at once
      PAIR_BOTH:  pairD = wrHigh ? PAIR_HIGH : (wrLow ? PAIR_LOW : PAIR_EMPTY);
      default:    pairD = PAIR_EMPTY;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pairQ <= PAIR_EMPTY;
    end else if (clkEn) begin
      pairQ <= pairD;
    end
  end

  // Old address stays in use until the pair completes
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      activeQ <= {HALF_RESET, HALF_RESET};
    end else if (clkEn && pairQ == PAIR_BOTH) begin
      activeQ <= {highQ, lowQ};
    end
  end

  assign pendingQ = (pairQ != PAIR_EMPTY);

endmodule

// ### dv/frame_store.sv
`timescale 1ns/1ps
// ----------------------------------------
// Output memory write side
// ----------------------------------------
// Keeps only the last word and its address; enough to see what the
// resizer would hand to memory for one beat.
module frame_store (
  input  wire logic        clk,
  input  wire logic        wrEn,
  input  wire logic [31:0] wrAddr,
  input  wire logic [31:0] wrData,
  output logic      [31:0] lastAddr,
  output logic      [31:0] lastData
);
  always_ff @(posedge clk) begin
    if (wrEn) begin
      lastAddr <= wrAddr;
      lastData <= wrData;
    end
  end
endmodule

// ### dv/resizer_b_output_address_regs_test.sv
`timescale 1ns/1ps
module resizer_b_output_address_regs_test;
  import rsz_out_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              clkEn = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic              pixelValid = 1'b0;
  logic [23:0]       pixelRgb = 24'h0;
  logic              lineStart = 1'b0;
  logic [LINE_W-1:0] lineIndex = 13'h0;
  logic              wrEn = 1'b0;
  logic [31:0]       prdata, pixelOut, lineAddr, baseAddr, startAddr, lastAddr, lastData;
  logic              pready, pslverr, rgbWidthSelect, horizontalReversal, alignError;
  int                nFail = 0;
  int                testsRun = 0;
  int                seed = 32'heb70;
  logic [7:0]        offs [5] = '{OFF_ALPHA, OFF_BASE_HIGH, OFF_BASE_LOW, OFF_START_HIGH,
                                  OFF_START_LOW};
  logic [31:0]       shadow [5] = '{default: 32'h0};
  logic [2:0]        ctlTab [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
  logic [2:0]        setTab [4] = '{3'h0, 3'h3, 3'h0, 3'h0};
  logic [2:0]        clrTab [4] = '{3'h3, 3'h3, 3'h7, 3'h3};
  logic [31:0]       expBase = 32'h0;
  logic [31:0]       expStart = 32'h0;

  always #50 core_clk = ~core_clk;

  resizer_b_output_address_regs i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pixelValid(pixelValid), .pixelRgb(pixelRgb), .pixelOut(pixelOut),
    .lineStart(lineStart), .lineIndex(lineIndex), .lineAddr(lineAddr),
    .baseAddr(baseAddr), .startAddr(startAddr), .rgbWidthSelect(rgbWidthSelect),
    .horizontalReversal(horizontalReversal), .alignError(alignError)
  );

  frame_store i_store (
    .clk(core_clk), .wrEn(wrEn), .wrAddr(lineAddr), .wrData(pixelOut),
    .lastAddr(lastAddr), .lastData(lastData)
  );

  task automatic wrapUp;
    if (nFail == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic checkVal(input logic [31:0] expv, input logic [31:0] got);
    testsRun++;
    if (got !== expv) begin
      nFail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, expv, got);
    end
  endtask

  task automatic checkFlag(input logic expv, input logic got);
    testsRun++;
    if (got !== expv) begin
      nFail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, expv, got);
    end
  endtask

  // Idle edge first, so back-to-back calls never drive psel twice in a step
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apbWr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apbXfer(1'b1, a, d, q, e);
  endtask

  task automatic regWr(input int i, input logic [31:0] d);
    apbWr(offs[i], d);
    shadow[i] = d;
  endtask

  task automatic readAll;
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 5; i++) begin
      apbXfer(1'b0, offs[i], 32'h0, q, e);
      checkVal(shadow[i], q);
      checkFlag(1'b0, e);
    end
  endtask

  function automatic logic [31:0] pixExp(input logic w, input logic [7:0] a,
                                         input logic [23:0] c);
    if (w) begin
      return {16'h0, c[23:19], c[15:10], c[7:3]};
    end
    return {a, c};
  endfunction

  task automatic emit(input logic [23:0] c, input logic [12:0] idx, input logic chk,
                      input logic [31:0] expPix, input logic [31:0] expLine);
    @(posedge core_clk);
    pixelValid <= 1'b1;
    pixelRgb <= c;
    lineStart <= 1'b1;
    lineIndex <= idx;
    @(posedge core_clk);
    pixelValid <= 1'b0;
    lineStart <= 1'b0;
    wrEn <= 1'b1;
    @(posedge core_clk);
    wrEn <= 1'b0;
    @(posedge core_clk);
    if (chk) begin
      checkVal(expPix, lastData);
    end
    checkVal(expLine, lastAddr);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    wrapUp();
  end

  initial begin
    logic [31:0] q, r;
    logic        e;
    logic [15:0] hi, lo, pitch;
    logic [2:0]  ctl;
    logic [12:0] idx;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    readAll();
    for (int m = 0; m < 4; m++) begin
      ctl = ctlTab[m];
      apbWr(OFF_CONTROL, {29'h0, ctl});
      r = $random(seed);
      regWr(0, {24'h0, r[7:0]});
      r = $random(seed);
      pitch = r[15:0] & 16'hffe0;
      apbWr(OFF_PITCH, {16'h0, pitch});
      r = $random(seed);
      hi = r[31:16];
      lo = (r[15:0] & ~{13'h0, clrTab[m]}) | {13'h0, setTab[m]};
      regWr(1, {16'h0, hi});
      repeat (2) @(posedge core_clk);
      checkVal(expBase, baseAddr);
      regWr(2, {16'h0, lo});
      repeat (2) @(posedge core_clk);
      expBase = {hi, lo};
      checkVal(expBase, baseAddr);
      r = $random(seed);
      hi = r[31:16];
      lo = (r[15:0] & ~{13'h0, clrTab[m]}) | {13'h0, setTab[m]};
      regWr(4, {16'h0, lo});
      repeat (2) @(posedge core_clk);
      checkVal(expStart, startAddr);
      regWr(3, {16'h0, hi});
      repeat (2) @(posedge core_clk);
      expStart = {hi, lo};
      checkVal(expStart, startAddr);
      checkFlag(1'b0, alignError);
      checkFlag(ctl[1], horizontalReversal);
      checkFlag(ctl[0], rgbWidthSelect);
      readAll();
      for (int k = 0; k < 6; k++) begin
        r = $random(seed);
        idx = (k == 0) ? 13'h1fff : (k == 1) ? 13'h0 : r[28:16];
        emit(r[23:0], idx, ctl[2], pixExp(ctl[0], shadow[0][7:0], r[23:0]),
             expStart + {19'h0, idx} * {16'h0, pitch});
      end
    end
    // Misaligned base with mirroring off must be flagged
    apbWr(OFF_CONTROL, 32'h0);
    regWr(1, 32'h0);
    apbXfer(1'b0, OFF_STATUS, 32'h0, q, e);
    checkVal(32'h1, q);
    regWr(2, 32'h1);
    repeat (2) @(posedge core_clk);
    checkFlag(1'b1, alignError);
    apbXfer(1'b0, OFF_STATUS, 32'h0, q, e);
    checkVal(32'h4, q);
    apbXfer(1'b0, OFF_PITCH, 32'h0, q, e);
    checkVal({16'h0, pitch}, q);
    // Frozen core drops the write
    clkEn <= 1'b0;
    apbWr(OFF_ALPHA, 32'h5a);
    clkEn <= 1'b1;
    readAll();
    apbXfer(1'b0, 8'h40, 32'h0, q, e);
    checkVal(32'h0, q);
    checkFlag(1'b1, e);
    wrapUp();
  end
endmodule
